// file: logic/vpiss_top.sv
// What this block does
// - A write to the single-step port arms the step logic and masks all other requests.
// - Once armed, two instruction cycles pass and then a request vectoring to 38H is raised.
// - The single-step request uses level 0, the lowest level, trap 38H.
// - Once its request is acknowledged the step logic clears itself and lifts the mask.
// - Clearing the step logic does not enable interrupts; only the enable instruction does.
// - Level n vectors to (7-n)*8 within the lowest 64 bytes.
// - Trap 0 is shared with the reset entry, so level 7 is rarely usable for devices.
// - In the acknowledge cycle the highest active level wins, level 7 highest.
// - After every acknowledge cycle without the external controller option, all interrupts are disabled.
// - Levels have no individual masks and no nesting; only global on/off, step masking and the strap gate them.
// - With the external controller option, the vectored facility is disabled.
// - The line-frequency tick normally sits on level 1, trap 30H.
`timescale 1ns/1ns
module vpiss_top
    import vpiss_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Bus request lines, active low, asynchronous
    input wire logic [7:0] i_request_n,
    // Processor status, same clock
    input wire logic i_instr_fetch,
    input wire logic i_vector_acknowledge_cycle,
    input wire logic i_step_port_write,
    input wire logic i_global_irq_on_instruction,
    input wire logic i_global_irq_off_instruction,
    // Strap
    input wire logic i_external_controller_option,
    // Outputs
    output logic o_irq,
    output logic o_irq_enabled,
    output logic [7:0] o_data_in,
    output logic o_data_in_oe,
    output logic o_step_busy
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        vpiss_step_t step;
        logic [1:0] count;
        logic ss_req;
        logic inte;
        logic [7:0] data;
        logic data_oe;
    } vpiss_state_t;

    vpiss_state_t state_ff;
    vpiss_state_t nxt_state;
    logic [7:0] req_sync;
    logic [7:0] active;
    logic [2:0] level;
    logic any;

    vpiss_sync #(.WIDTH(VPISS_LEVELS)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(~i_request_n),
        .o_sync(req_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // No per-level masks exist; only step masking and the strap gate requests
    always_comb begin
        active = '0;
        if (!i_external_controller_option) begin
            if (state_ff.step != VPISS_IDLE) begin
                active[VPISS_SS_LEVEL] = state_ff.ss_req;
            end else begin
                active = req_sync;
            end
        end
    end

    // Highest level wins; 7 and its trap 0 collide with reset entry
    always_comb begin
        level = 3'h0;
        any = 1'b0;
        for (int i = 0; i < VPISS_LEVELS; i++) begin
            if (active[i]) begin
                level = 3'(i);
                any = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_state.data_oe = 1'b0;
        if (i_global_irq_on_instruction) begin
            nxt_state.inte = 1'b1;
        end
        if (i_global_irq_off_instruction) begin
            nxt_state.inte = 1'b0;
        end
        case (state_ff.step)
            VPISS_IDLE: begin
                nxt_state.ss_req = 1'b0;
                nxt_state.count = '0;
                if (i_step_port_write) begin
                    nxt_state.step = VPISS_ARMED;
                end
            end
            VPISS_ARMED, VPISS_WAIT2: begin
                if (i_instr_fetch) begin
                    nxt_state.count = state_ff.count + 2'h1;
                    if (state_ff.count + 2'h1 == VPISS_STEP_CYCLES) begin
                        nxt_state.step = VPISS_FIRE;
                        nxt_state.ss_req = 1'b1;
                    end else begin
                        nxt_state.step = VPISS_WAIT2;
                    end
                end
            end
            VPISS_FIRE: begin
                // Request held until taken; then step logic clears
                if (i_vector_acknowledge_cycle) begin
                    nxt_state.step = VPISS_IDLE;
                    nxt_state.ss_req = 1'b0;
                end
            end
            default: begin
                nxt_state.step = VPISS_IDLE;
            end
        endcase
        if (i_vector_acknowledge_cycle && !i_external_controller_option) begin
            nxt_state.inte = 1'b0;
            // Restart opcode carries trap (7-level)*8
            nxt_state.data = VPISS_RST_BASE | ({5'h0, 3'h7 - level} << 3);
            nxt_state.data_oe = any;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= '{step: VPISS_IDLE, count: 2'h0, ss_req: 1'b0, inte: 1'b0,
                          data: 8'h00, data_oe: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_irq = any & state_ff.inte;
    assign o_irq_enabled = state_ff.inte;
    assign o_data_in = state_ff.data;
    assign o_data_in_oe = state_ff.data_oe;
    assign o_step_busy = state_ff.step != VPISS_IDLE;
endmodule

// file: logic/vpiss_pkg.sv
package vpiss_pkg;
    // Instruction cycles that pass before the single-step request fires
    localparam logic [1:0] VPISS_STEP_CYCLES = 2'h2;
    // Trap spacing in bytes
    localparam logic [7:0] VPISS_TRAP_STRIDE = 8'h08;
    // Restart opcode base; trap address sits in bits 5:3
    localparam logic [7:0] VPISS_RST_BASE = 8'hC7;
    localparam logic [7:0] VPISS_RST_MASK = 8'h38;
    localparam logic [7:0] VPISS_SS_TRAP = 8'h38;
    localparam logic [7:0] VPISS_RTC_TRAP = 8'h30;
    localparam int VPISS_LEVELS = 8;
    localparam int VPISS_SS_LEVEL = 0;
    localparam int VPISS_RTC_LEVEL = 1;

    typedef enum logic [1:0] {
        VPISS_IDLE = 2'h0,
        VPISS_ARMED = 2'h1,
        VPISS_WAIT2 = 2'h3,
        VPISS_FIRE = 2'h2
    } vpiss_step_t;

    typedef struct packed {
        logic [7:0] req_n;
        logic fetch;
        logic ack;
        logic step_wr;
        logic ext_opt;
    } vpiss_bus_in_t;

    typedef struct packed {
        logic irq;
        logic [7:0] data;
        logic data_oe;
        logic [7:0] trap;
        logic step_busy;
    } vpiss_bus_out_t;
endpackage

// file: logic/vpiss_sync.sv
`timescale 1ns/1ns
module vpiss_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two stages per bit; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= i_async[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_ff;
endmodule

// file: sim/vpiss_checker.sv
`timescale 1ns/1ns
module vpiss_checker (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Watched inputs
    input wire logic i_vector_acknowledge_cycle,
    input wire logic i_step_port_write,
    input wire logic i_global_irq_on_instruction,
    input wire logic i_global_irq_off_instruction,
    input wire logic i_external_controller_option,
    // Watched outputs
    input wire logic o_irq,
    input wire logic o_irq_enabled,
    input wire logic [7:0] o_data_in,
    input wire logic o_data_in_oe,
    input wire logic o_step_busy
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    a_oe_after_ack: assert property (o_data_in_oe |-> $past(i_vector_acknowledge_cycle))
        else $error("vector without acknowledge");
    a_opcode_form: assert property (o_data_in_oe |-> (o_data_in | 8'h38) == 8'hFF)
        else $error("bad restart opcode");
    a_ack_disables: assert property (i_vector_acknowledge_cycle && !i_external_controller_option |=> !o_irq_enabled)
        else $error("enable kept after acknowledge");
    a_off_disables: assert property (i_global_irq_off_instruction |=> !o_irq_enabled)
        else $error("enable kept after off");
    a_irq_needs_en: assert property (o_irq |-> o_irq_enabled)
        else $error("irq while disabled");
    // Step clears only on its own acknowledge, which leaves interrupts off
    a_step_no_enable: assert property ($fell(o_step_busy) && !$past(i_external_controller_option) |-> !o_irq_enabled)
        else $error("enable set by step clear");
    a_strap_blocks: assert property (i_external_controller_option && $past(i_external_controller_option) |-> !o_irq && !o_data_in_oe)
        else $error("vectoring with strap set");
    a_step_arms: assert property (i_step_port_write && !i_external_controller_option |=> o_step_busy)
        else $error("step not armed");
    a_step_clears: assert property (o_step_busy && o_irq && i_vector_acknowledge_cycle |=> !o_step_busy)
        else $error("step not cleared");
    cover property (o_data_in_oe);
    cover property ($rose(o_step_busy));
    cover property (o_data_in_oe && o_data_in == 8'hFF);
endmodule

// file: sim/vpiss_dev_model.sv
`timescale 1ns/1ns
module vpiss_dev_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Raise and service strobes per level
    input wire logic [7:0] i_raise,
    input wire logic [7:0] i_clear,
    // Bus request lines
    output logic [7:0] o_request_n
);
    logic [7:0] pend_ff;
    // Held low until serviced at the device itself
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pend_ff <= 8'h00;
        end else begin
            pend_ff <= (pend_ff | i_raise) & ~i_clear;
        end
    end
    assign o_request_n = ~pend_ff;
endmodule

// file: sim/vpiss_top_tb.sv
`timescale 1ns/1ns
module vpiss_top_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic strap = 1'b0;
    logic [4:0] pls = 5'h00;
    logic [7:0] raise = 8'h00;
    logic [7:0] clr = 8'h00;
    logic [7:0] req_n;
    logic [7:0] data;
    logic irq, en, oe, busy;
    int failures = 0;
    int compares = 0;
    vpiss_dev_model i_dev(.i_clock, .i_rst, .i_raise(raise), .i_clear(clr), .o_request_n(req_n));
    vpiss_top i_dut(.i_clock, .i_rst, .i_request_n(req_n), .i_instr_fetch(pls[1]),
        .i_vector_acknowledge_cycle(pls[2]), .i_step_port_write(pls[0]),
        .i_global_irq_on_instruction(pls[3]), .i_global_irq_off_instruction(pls[4]),
        .i_external_controller_option(strap), .o_irq(irq), .o_irq_enabled(en),
        .o_data_in(data), .o_data_in_oe(oe), .o_step_busy(busy));
    initial forever #5 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task pulse(input logic [4:0] p);
        pls = p;
        @(negedge i_clock);
        pls = 5'h00;
        @(negedge i_clock);
    endtask
    task dev(input logic [7:0] r, input logic [7:0] c);
        raise = r;
        clr = c;
        @(negedge i_clock);
        raise = 8'h00;
        clr = 8'h00;
        repeat (4) @(negedge i_clock);
    endtask
    // Opcode is caught whichever edge it lands on; 00 means none
    task ack(input logic [7:0] exp);
        logic [7:0] got;
        got = 8'h00;
        pls = 5'h04;
        repeat (3) begin
            @(negedge i_clock);
            pls = 5'h00;
            if (oe === 1'b1) got = data;
        end
        chk(got, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_levels;
        for (int n = 0; n < 8; n++) begin
            dev(8'h01 << n, 8'h00);
            pulse(5'h08);
            chk(8'(irq), 8'h01);
            ack(8'hC7 | (8'(7 - n) << 3));
            chk(8'(en), 8'h00);
            dev(8'h00, 8'h01 << n);
        end
    endtask
    task t_prio;
        dev(8'h4A, 8'h00);
        pulse(5'h08);
        ack(8'hCF);
        pulse(5'h08);
        pulse(5'h10);
        chk(8'(en), 8'h00);
        dev(8'h00, 8'h4A);
    endtask
    task t_step;
        dev(8'h08, 8'h00);
        pulse(5'h01);
        chk(8'(busy), 8'h01);
        pulse(5'h08);
        chk(8'(irq), 8'h00);
        pulse(5'h02);
        repeat (2) @(negedge i_clock);
        chk(8'(irq), 8'h00);
        pulse(5'h02);
        repeat (2) @(negedge i_clock);
        chk(8'(irq), 8'h01);
        ack(8'hFF);
        chk({busy, irq, en}, 8'h00);
        pulse(5'h08);
        ack(8'hE7);
        dev(8'h00, 8'h08);
    endtask
    task t_strap;
        strap = 1'b1;
        dev(8'h10, 8'h00);
        pulse(5'h08);
        chk(8'(irq), 8'h00);
        ack(8'h00);
        pulse(5'h10);
        strap = 1'b0;
    endtask
    task wrap_up;
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge i_clock);
        i_rst = 1'b0;
        t_levels;
        t_prio;
        t_step;
        t_strap;
        wrap_up;
    end
    // Whole run needs about 1.9 us
    initial begin
        #20000;
        failures++;
        wrap_up;
    end
endmodule
bind vpiss_top vpiss_checker i_chk(.i_clock, .i_rst, .i_vector_acknowledge_cycle, .i_step_port_write,
    .i_global_irq_on_instruction, .i_global_irq_off_instruction, .i_external_controller_option,
    .o_irq, .o_irq_enabled, .o_data_in, .o_data_in_oe, .o_step_busy);
